// File: hw/pulse_cnt.v
`timescale 1ns/10ps
// Counter that reports when a condition has held for LIMIT cycles
module pulse_cnt #(
  parameter W     = 11,
  parameter LIMIT = 24
) (
  input  wire         clk,    // Block clock
  input  wire         rst_n,  // Async reset, active low
  input  wire         run,    // Count while high, clear when low
  output wire         done    // Held condition reached LIMIT
);
  // Limit cut to the counter width on purpose
  localparam integer LIMIT_I = LIMIT;
  localparam [W-1:0] LIM     = LIMIT_I[W-1:0];
  reg [W-1:0] cnt_reg;

  // Saturate at the limit so done stays up while run holds
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      cnt_reg <= {W{1'b0}};
    else if (!run)
      cnt_reg <= {W{1'b0}};
    else if (cnt_reg != LIM)
      cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
  end

  assign done = (cnt_reg == LIM);
endmodule

// File: hw/pwr_rst_map.vh
`ifndef PWR_RST_MAP_VH
`define PWR_RST_MAP_VH
// Register offsets on the plain register port
`define PWR_CTRL_ADDR     4'h0
`define PWR_STAT_ADDR     4'h1
// Field positions inside the power control register
`define IDLE_BIT_POS      0
`define PDOWN_BIT_POS     1
`define FLAG_A_POS        2
`define FLAG_B_POS        3
`define DSPEED_POS        7
// Reset values
`define PWR_CTRL_RST      8'h00
`define RESET_VECTOR      16'h0000
// Timing counts in oscillator periods
`define WARM_RST_PERIODS  24
`define WDT_PULSE_PERIODS 96
`define KBD_WAKE_CLOCKS   1024
// Mode encodings
`define MODE_RUN          2'h0
`define MODE_IDLE         2'h1
`define MODE_PDOWN        2'h2
`define MODE_WAKE         2'h3
`endif

// File: hw/reset_idle_powerdown_control.v
`timescale 1ns/10ps
`include "pwr_rst_map.vh"
module reset_idle_powerdown_control (
  input  wire        MCLK_IN,        // Oscillator clock, 10 MHz
  input  wire        RESETN_IN,      // Power-on reset, active low
  input  wire        RST_PIN_IN,     // Reset pin level, active high
  input  wire        WDT_EXPIRE_IN,  // Watchdog expiry, one-cycle pulse
  input  wire        IRQ_ZERO_N_IN,  // External irq zero pin, low active
  input  wire        IRQ_ONE_N_IN,   // External irq one pin, low active
  input  wire        KBD_IRQ_IN,     // Keyboard interrupt level
  input  wire        EN_IRQ_ZERO_IN, // Irq zero enabled
  input  wire        EN_IRQ_ONE_IN,  // Irq one enabled
  input  wire        EN_KBD_IN,      // Keyboard irq enabled
  input  wire        IRQ_ZERO_HI_IN, // Irq zero has higher priority
  input  wire        IRQ_PEND_IN,    // Any enabled irq pending (core)
  input  wire        VECTOR_IN,      // Core vectors to a handler, pulse
  input  wire        EXT_CODE_IN,    // Running from external program mem
  input  wire [7:0]  PORT0_DATA_IN,  // Port 0 latch from core
  input  wire [7:0]  PORT2_DATA_IN,  // Port 2 latch from core
  input  wire [7:0]  PORT2_ADDR_IN,  // Port 2 address from fetch unit
  input  wire        ALE_CORE_IN,    // Address latch strobe from core
  input  wire        PSS_CORE_IN,    // Program store strobe from core
  input  wire [3:0]  ADDR_IN,        // Register address
  input  wire [7:0]  WDATA_IN,       // Register write data
  input  wire        WR_IN,          // Register write strobe
  input  wire        RD_IN,          // Register read strobe
  output reg  [7:0]  RDATA_OUT,      // Read data, cycle after strobe
  output reg         RST_PIN_OUT,    // Reset pin drive value (high)
  output reg         RST_PIN_OE_OUT, // Reset pin drive enable
  output reg         CORE_RST_OUT,   // Internal core reset, active high
  output reg  [15:0] FETCH_ADDR_OUT, // Start fetch address after reset
  output reg         CPU_CLK_EN_OUT, // CPU clock gate enable
  output reg         PER_CLK_EN_OUT, // Peripheral clock gate enable
  output reg         OSC_EN_OUT,     // Oscillator run enable
  output reg         ALE_OUT,        // Address latch strobe pin
  output reg         PSS_OUT,        // Program store strobe pin
  output reg  [7:0]  PORT0_OUT,      // Port 0 pin value
  output reg         PORT0_OE_OUT,   // Port 0 drive enable
  output reg  [7:0]  PORT2_OUT,      // Port 2 pin value
  output reg         WAKE_OUT        // Wake from power-down, pulse
);
  // Synchronised pin levels
  wire rst_pin_s;
  wire irq0_n_s;
  wire irq1_n_s;
  wire kbd_s;

  sync2 #(.RST_VAL(1'b0)) u_sync_rst (
    .clk   (MCLK_IN),
    .rst_n (RESETN_IN),
    .d     (RST_PIN_IN),
    .q     (rst_pin_s)
  );
  sync2 #(.RST_VAL(1'b1)) u_sync_i0 (
    .clk   (MCLK_IN),
    .rst_n (RESETN_IN),
    .d     (IRQ_ZERO_N_IN),
    .q     (irq0_n_s)
  );
  sync2 #(.RST_VAL(1'b1)) u_sync_i1 (
    .clk   (MCLK_IN),
    .rst_n (RESETN_IN),
    .d     (IRQ_ONE_N_IN),
    .q     (irq1_n_s)
  );
  sync2 #(.RST_VAL(1'b0)) u_sync_kbd (
    .clk   (MCLK_IN),
    .rst_n (RESETN_IN),
    .d     (KBD_IRQ_IN),
    .q     (kbd_s)
  );

  // Warm reset qualification: raw oscillator periods, no speed dependence
  wire warm_ok;
  pulse_cnt #(.W(11), .LIMIT(`WARM_RST_PERIODS)) u_warm (
    .clk   (MCLK_IN),
    .rst_n (RESETN_IN),
    .run   (rst_pin_s),
    .done  (warm_ok)
  );

  // Keyboard wake delay counted on the restarted clock
  reg  kbd_wait_reg;
  wire kbd_done;
  pulse_cnt #(.W(11), .LIMIT(`KBD_WAKE_CLOCKS)) u_kbd (
    .clk   (MCLK_IN),
    .rst_n (RESETN_IN),
    .run   (kbd_wait_reg),
    .done  (kbd_done)
  );

  // Watchdog pulse length counter
  reg  [6:0] wdt_cnt_reg;
  reg  [6:0] wdt_cnt_next;
  localparam integer WDT_LAST_I = `WDT_PULSE_PERIODS - 1;
  localparam [6:0]   WDT_LAST   = WDT_LAST_I[6:0];

  // Power control register and mode state
  reg  [7:0] pwr_ctrl_reg;
  reg  [7:0] pwr_ctrl_next;
  reg  [1:0] mode_reg;
  reg  [1:0] mode_next;
  reg        kbd_wait_next;
  reg        wake_next;
  reg  [7:0] port0_hold_reg;
  reg  [7:0] port2_hold_reg;
  reg        wake_src_reg;  // Wake came from external pin
  reg        wake_src_next;
  reg  [1:0] low_seen_reg;  // External pins seen low since wake began
  reg  [1:0] low_seen_next;

  localparam [1:0] RUN   = `MODE_RUN;
  localparam [1:0] IDLE  = `MODE_IDLE;
  localparam [1:0] PDOWN = `MODE_PDOWN;
  localparam [1:0] WAKE  = `MODE_WAKE;

  // Enabled wake sources while powered down
  wire irq0_act = EN_IRQ_ZERO_IN & ~irq0_n_s;
  wire irq1_act = EN_IRQ_ONE_IN & ~irq1_n_s;
  wire kbd_act  = EN_KBD_IN & kbd_s;
  wire ext_low  = irq0_act | irq1_act;
  // Completion on the first release of a pin that was seen low; a pin
  // that never went low cannot end the wait, so a single-pin wake with
  // both sources enabled still waits for its own release
  wire [1:0] ext_now = {irq1_act, irq0_act};
  wire       ext_rel = wake_src_reg & (|(low_seen_reg & ~ext_now));

  // Only a qualified reset pin level resets the core; a watchdog pulse acts only through the pin
  wire hw_reset = warm_ok;
  wire wr_ctrl  = WR_IN & (ADDR_IN == `PWR_CTRL_ADDR);

  // Mode sequencing
  always @* begin
    mode_next     = mode_reg;
    pwr_ctrl_next = pwr_ctrl_reg;
    kbd_wait_next = kbd_wait_reg;
    wake_next     = 1'b0;
    wake_src_next = wake_src_reg;
    low_seen_next = low_seen_reg;
    case (mode_reg)
      RUN: begin
        if (wr_ctrl) begin
          pwr_ctrl_next = WDATA_IN;
          // The writing instruction completes; mode changes next cycle
          if (WDATA_IN[`PDOWN_BIT_POS])
            mode_next = PDOWN;
          else if (WDATA_IN[`IDLE_BIT_POS])
            mode_next = IDLE;
        end
      end
      IDLE: begin
        // State held: only the clock to the CPU stops
        if (IRQ_PEND_IN) begin
          pwr_ctrl_next[`IDLE_BIT_POS] = 1'b0;
          mode_next = RUN;
        end
      end
      PDOWN: begin
        // Only enabled external or keyboard sources wake the part
        if (ext_low) begin
          wake_src_next = 1'b1;
          low_seen_next = ext_now;
          mode_next     = WAKE;
        end else if (kbd_act) begin
          kbd_wait_next = 1'b1;
          mode_next     = WAKE;
        end
      end
      WAKE: begin
        // Oscillator runs again; finish on pin release or key delay
        low_seen_next = low_seen_reg | ext_now;
        if (ext_rel | (kbd_wait_reg & kbd_done)) begin
          mode_next     = RUN;
          kbd_wait_next = 1'b0;
          wake_src_next = 1'b0;
          low_seen_next = 2'h0;
          wake_next     = 1'b1;
        end
      end
      default: mode_next = RUN;
    endcase
    // Vectoring after any wake clears both bits, idle is not entered;
    // a control write in the same cycle wins over the clear
    if (VECTOR_IN && mode_reg == RUN && !wr_ctrl) begin
      pwr_ctrl_next[`IDLE_BIT_POS]  = 1'b0;
      pwr_ctrl_next[`PDOWN_BIT_POS] = 1'b0;
    end
  end

  // Watchdog drives the reset pin for a fixed count
  always @* begin
    wdt_cnt_next = wdt_cnt_reg;
    if (WDT_EXPIRE_IN)
      wdt_cnt_next = WDT_LAST;
    else if (wdt_cnt_reg != 7'h00)
      wdt_cnt_next = wdt_cnt_reg - 7'h01;
  end

  // Pin stays high from the expiry edge until the edge after the count empties
  always @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      wdt_cnt_reg    <= 7'h00;
      RST_PIN_OUT    <= 1'b0;
      RST_PIN_OE_OUT <= 1'b0;
    end else begin
      wdt_cnt_reg    <= wdt_cnt_next;
      RST_PIN_OUT    <= WDT_EXPIRE_IN | (wdt_cnt_reg != 7'h00);
      RST_PIN_OE_OUT <= WDT_EXPIRE_IN | (wdt_cnt_reg != 7'h00);
    end
  end

  // State registers; reset exit rewrites the control register
  always @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      pwr_ctrl_reg <= `PWR_CTRL_RST;
      mode_reg     <= RUN;
      kbd_wait_reg <= 1'b0;
      wake_src_reg <= 1'b0;
      low_seen_reg <= 2'h0;
      WAKE_OUT     <= 1'b0;
    end else if (hw_reset) begin
      pwr_ctrl_reg <= `PWR_CTRL_RST;
      mode_reg     <= RUN;
      kbd_wait_reg <= 1'b0;
      wake_src_reg <= 1'b0;
      low_seen_reg <= 2'h0;
      WAKE_OUT     <= 1'b0;
    end else begin
      // Interrupt exit keeps every other bit untouched
      pwr_ctrl_reg <= pwr_ctrl_next;
      mode_reg     <= mode_next;
      kbd_wait_reg <= kbd_wait_next;
      wake_src_reg <= wake_src_next;
      low_seen_reg <= low_seen_next;
      WAKE_OUT     <= wake_next;
    end
  end

  // Core reset and start address
  always @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      CORE_RST_OUT   <= 1'b1;
      FETCH_ADDR_OUT <= `RESET_VECTOR;
    end else begin
      CORE_RST_OUT   <= hw_reset;
      FETCH_ADDR_OUT <= `RESET_VECTOR;
    end
  end

  // Clock gates: RAM and registers keep state since nothing is reset
  always @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      CPU_CLK_EN_OUT <= 1'b1;
      PER_CLK_EN_OUT <= 1'b1;
      OSC_EN_OUT     <= 1'b1;
    end else begin
      CPU_CLK_EN_OUT <= (mode_next == RUN) | hw_reset;
      PER_CLK_EN_OUT <= (mode_next != PDOWN) | hw_reset;
      // Oscillator stops in power-down; wake or reset restarts it
      OSC_EN_OUT     <= (mode_next != PDOWN) | hw_reset | rst_pin_s;
    end
  end

  // Pin states per mode
  always @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ALE_OUT        <= 1'b1;
      PSS_OUT        <= 1'b1;
      PORT0_OUT      <= 8'hff;
      PORT0_OE_OUT   <= 1'b0;
      PORT2_OUT      <= 8'hff;
      port0_hold_reg <= 8'hff;
      port2_hold_reg <= 8'hff;
    end else begin
      // Freeze port latches at the moment of entry
      if (mode_reg == RUN) begin
        port0_hold_reg <= PORT0_DATA_IN;
        port2_hold_reg <= PORT2_DATA_IN;
      end
      case (mode_next)
        IDLE: begin
          ALE_OUT      <= 1'b1;
          PSS_OUT      <= 1'b1;
          PORT0_OUT    <= port0_hold_reg;
          PORT0_OE_OUT <= ~EXT_CODE_IN;
          PORT2_OUT    <= EXT_CODE_IN ? PORT2_ADDR_IN : port2_hold_reg;
        end
        PDOWN, WAKE: begin
          ALE_OUT      <= 1'b0;
          PSS_OUT      <= 1'b0;
          PORT0_OUT    <= port0_hold_reg;
          PORT0_OE_OUT <= ~EXT_CODE_IN;
          PORT2_OUT    <= port2_hold_reg;
        end
        default: begin
          ALE_OUT      <= ALE_CORE_IN;
          PSS_OUT      <= PSS_CORE_IN;
          PORT0_OUT    <= PORT0_DATA_IN;
          PORT0_OE_OUT <= 1'b1;
          PORT2_OUT    <= EXT_CODE_IN ? PORT2_ADDR_IN : PORT2_DATA_IN;
        end
      endcase
    end
  end

  // Register read port, data one cycle after the strobe
  always @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN)
      RDATA_OUT <= 8'h00;
    else if (RD_IN) begin
      case (ADDR_IN)
        `PWR_CTRL_ADDR: RDATA_OUT <= pwr_ctrl_reg;
        `PWR_STAT_ADDR: RDATA_OUT <= {4'h0, wake_src_reg, kbd_wait_reg,
                                      mode_reg};
        default:        RDATA_OUT <= 8'h00;
      endcase
    end else
      RDATA_OUT <= 8'h00;
  end
endmodule

// File: hw/sync2.v
`timescale 1ns/10ps
// Two-stage synchroniser for one asynchronous level
module sync2 #(
  parameter RST_VAL = 1'b0
) (
  input  wire clk,    // Block clock
  input  wire rst_n,  // Async reset, active low
  input  wire d,      // Asynchronous level
  output reg  q       // Synchronised level
);
  reg meta_reg;

  // First stage feeds only the second
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// File: tb/ext_wake_model.sv
`timescale 1ns/10ps
// Reset circuit and wake pins outside the device
module ext_wake_model (
  input  wire  clk_in,     // Oscillator clock
  output logic rst_out,    // Reset pin drive, pull-down when idle
  output logic irq0_n_out, // Irq zero pin, pull-up when idle
  output logic irq1_n_out, // Irq one pin, pull-up when idle
  output logic kbd_out     // Keyboard line
);
  // Released lines rest at their pull levels
  initial begin
    rst_out = 1'b0;
    irq0_n_out = 1'b1;
    irq1_n_out = 1'b1;
    kbd_out = 1'b0;
  end
  // Reset held n cycles; below 24 is a deliberate short pulse
  task reset_pin(input int n);
    @(posedge clk_in);
    rst_out <= 1'b1;
    repeat (n) @(posedge clk_in);
    rst_out <= 1'b0;
  endtask
  // Pins held past oscillator restart; zero is released first
  task irq_pins(input logic z, input logic o, input int n);
    @(posedge clk_in);
    irq0_n_out <= !z;
    irq1_n_out <= !o;
    repeat (n) @(posedge clk_in);
    irq0_n_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    irq1_n_out <= 1'b1;
  endtask
  // Key held through the whole restart wait
  task kbd_press(input int n);
    @(posedge clk_in);
    kbd_out <= 1'b1;
    repeat (n) @(posedge clk_in);
    kbd_out <= 1'b0;
  endtask
endmodule

// File: tb/reset_idle_powerdown_control_tb.sv
`timescale 1ns/10ps
`include "pwr_rst_map.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
`define UNTIL(c, n) for (k = 0; k < (n) && !(c); k++) @(posedge MCLK_IN);
module reset_idle_powerdown_control_tb;
  logic MCLK_IN = 1'b0, RESETN_IN = 1'b0, WDT_EXPIRE_IN = 1'b0;
  logic EN_IRQ_ZERO_IN = 1'b1, EN_IRQ_ONE_IN = 1'b1, EN_KBD_IN = 1'b1;
  logic IRQ_ZERO_HI_IN = 1'b1, IRQ_PEND_IN = 1'b0, VECTOR_IN = 1'b0;
  logic EXT_CODE_IN = 1'b0, ALE_CORE_IN = 1'b0, PSS_CORE_IN = 1'b0;
  logic [7:0] PORT0_DATA_IN = 8'h00, PORT2_DATA_IN = 8'h00;
  logic [7:0] PORT2_ADDR_IN = 8'h00, WDATA_IN = 8'h00, d;
  logic [3:0] ADDR_IN = 4'h0;
  logic WR_IN = 1'b0, RD_IN = 1'b0, rd_d = 1'b0;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  wire rst_drv, RST_PIN_IN, IRQ_ZERO_N_IN, IRQ_ONE_N_IN, KBD_IRQ_IN;
  wire [7:0] RDATA_OUT, PORT0_OUT, PORT2_OUT;
  wire [15:0] FETCH_ADDR_OUT;
  wire RST_PIN_OUT, RST_PIN_OE_OUT, CORE_RST_OUT, CPU_CLK_EN_OUT;
  wire PER_CLK_EN_OUT, OSC_EN_OUT, ALE_OUT, PSS_OUT, PORT0_OE_OUT, WAKE_OUT;
  int failures = 0, checks = 0, k, i, cyc = 0;
  // Reset pin is wired-or of outside drive and watchdog drive
  assign RST_PIN_IN = rst_drv | (RST_PIN_OE_OUT & RST_PIN_OUT);
  reset_idle_powerdown_control i_reset_idle_powerdown_control (
    .MCLK_IN, .RESETN_IN, .RST_PIN_IN, .WDT_EXPIRE_IN, .IRQ_ZERO_N_IN,
    .IRQ_ONE_N_IN, .KBD_IRQ_IN, .EN_IRQ_ZERO_IN, .EN_IRQ_ONE_IN, .EN_KBD_IN,
    .IRQ_ZERO_HI_IN, .IRQ_PEND_IN, .VECTOR_IN, .EXT_CODE_IN, .PORT0_DATA_IN,
    .PORT2_DATA_IN, .PORT2_ADDR_IN, .ALE_CORE_IN, .PSS_CORE_IN, .ADDR_IN,
    .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT, .RST_PIN_OUT, .RST_PIN_OE_OUT,
    .CORE_RST_OUT, .FETCH_ADDR_OUT, .CPU_CLK_EN_OUT, .PER_CLK_EN_OUT,
    .OSC_EN_OUT, .ALE_OUT, .PSS_OUT, .PORT0_OUT, .PORT0_OE_OUT, .PORT2_OUT,
    .WAKE_OUT);
  ext_wake_model i_ext_wake_model (.clk_in(MCLK_IN), .rst_out(rst_drv),
    .irq0_n_out(IRQ_ZERO_N_IN), .irq1_n_out(IRQ_ONE_N_IN),
    .kbd_out(KBD_IRQ_IN));
  always #50 MCLK_IN = ~MCLK_IN;
  task give_verdict;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge MCLK_IN);
    ADDR_IN <= a;
    WDATA_IN <= v;
    WR_IN <= 1'b1;
    @(posedge MCLK_IN);
    WR_IN <= 1'b0;
  endtask
  // Read with a mask of the bits whose value is known
  task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] x);
    @(posedge MCLK_IN);
    ADDR_IN <= a;
    RD_IN <= 1'b1;
    exp_q.push_back({m, x});
    @(posedge MCLK_IN);
    RD_IN <= 1'b0;
  endtask
  task vec;
    @(posedge MCLK_IN);
    VECTOR_IN <= 1'b1;
    @(posedge MCLK_IN);
    VECTOR_IN <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge MCLK_IN) begin
    rd_d <= RD_IN;
    cyc <= cyc + 1;
    if (rd_d) begin
      e = exp_q.pop_front();
      `CHK(RDATA_OUT & e[15:8], e[7:0])
    end
    if (cyc > 20000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(72561));
    repeat (2) @(posedge MCLK_IN);
    RESETN_IN <= 1'b1;
    repeat (2) @(posedge MCLK_IN);
    @(negedge MCLK_IN);
    `CHK(CORE_RST_OUT, 1'b0)
    `CHK(FETCH_ADDR_OUT, `RESET_VECTOR)
    rd(`PWR_CTRL_ADDR, 8'hff, `PWR_CTRL_RST);
    rd(`PWR_STAT_ADDR, 8'h03, {6'h00, `MODE_RUN});
    d = 8'($urandom) & 8'h8c;
    wr(`PWR_CTRL_ADDR, d);
    wr(4'h9, 8'hff);
    rd(`PWR_CTRL_ADDR, 8'h8f, d);
    rd(4'h9, 8'hff, 8'h00);
    // Idle from internal then external code; core strobes low
    for (i = 0; i < 2; i++) begin
      EXT_CODE_IN <= i[0];
      PORT2_DATA_IN <= 8'($urandom);
      PORT2_ADDR_IN <= 8'($urandom);
      PORT0_DATA_IN <= 8'($urandom);
      wr(`PWR_CTRL_ADDR, d | 8'h01);
      @(negedge MCLK_IN);
      `CHK({CPU_CLK_EN_OUT, PER_CLK_EN_OUT, ALE_OUT, PSS_OUT}, 4'h7)
      `CHK(PORT2_OUT, i ? PORT2_ADDR_IN : PORT2_DATA_IN)
      `CHK(PORT0_OUT, PORT0_DATA_IN)
      `CHK(PORT0_OE_OUT, ~i[0])
      @(posedge MCLK_IN);
      IRQ_PEND_IN <= 1'b1;
      @(posedge MCLK_IN);
      IRQ_PEND_IN <= 1'b0;
      @(negedge MCLK_IN);
      `CHK(CPU_CLK_EN_OUT, 1'b1)
      rd(`PWR_CTRL_ADDR, 8'h8f, d);
    end
    // Short pulse ignored in double speed, full one ends idle
    wr(`PWR_CTRL_ADDR, 8'h81);
    i_ext_wake_model.reset_pin(20);
    repeat (4) @(posedge MCLK_IN);
    @(negedge MCLK_IN);
    `CHK({CORE_RST_OUT, CPU_CLK_EN_OUT}, 2'h0)
    i_ext_wake_model.reset_pin(`WARM_RST_PERIODS + 2);
    // Sync stages put the core reset one edge after the pin drops
    @(posedge MCLK_IN);
    @(negedge MCLK_IN);
    `CHK(CORE_RST_OUT, 1'b1)
    repeat (5) @(posedge MCLK_IN);
    rd(`PWR_CTRL_ADDR, 8'hff, 8'h00);
    // Power-down with core strobes high; disabled pin must not wake
    ALE_CORE_IN <= 1'b1;
    PSS_CORE_IN <= 1'b1;
    EN_IRQ_ONE_IN <= 1'b0;
    wr(`PWR_CTRL_ADDR, 8'h0e);
    @(negedge MCLK_IN);
    `CHK({OSC_EN_OUT, PER_CLK_EN_OUT, ALE_OUT, PSS_OUT}, 4'h0)
    i_ext_wake_model.irq_pins(1'b0, 1'b1, 10);
    @(negedge MCLK_IN);
    `CHK(OSC_EN_OUT, 1'b0)
    // Let the released pin clear the synchroniser before enabling it
    repeat (3) @(posedge MCLK_IN);
    EN_IRQ_ONE_IN <= 1'b1;
    fork
      i_ext_wake_model.irq_pins(1'b1, 1'b0, 20);
      begin
        `UNTIL(OSC_EN_OUT, 10)
        `CHK(OSC_EN_OUT, 1'b1)
        `UNTIL(WAKE_OUT, 40)
        `CHK(k > 12 && WAKE_OUT, 1'b1)
      end
    join
    vec();
    rd(`PWR_CTRL_ADDR, 8'h8f, 8'h0c);
    // Both bits and both pins: first release completes exit
    wr(`PWR_CTRL_ADDR, 8'h03);
    fork
      i_ext_wake_model.irq_pins(1'b1, 1'b1, 20);
      begin
        `UNTIL(WAKE_OUT, 60)
        `CHK({WAKE_OUT, IRQ_ONE_N_IN}, 2'h2)
      end
    join
    vec();
    @(negedge MCLK_IN);
    `CHK(CPU_CLK_EN_OUT, 1'b1)
    rd(`PWR_CTRL_ADDR, 8'h03, 8'h00);
    // Keyboard wake waits the full restart count
    wr(`PWR_CTRL_ADDR, 8'h02);
    fork
      i_ext_wake_model.kbd_press(1100);
      begin
        `UNTIL(WAKE_OUT, 1200)
        `CHK(k >= `KBD_WAKE_CLOCKS && k < 1040, 1'b1)
      end
    join
    // Watchdog drives the pin, which also resets the core
    @(posedge MCLK_IN);
    WDT_EXPIRE_IN <= 1'b1;
    @(posedge MCLK_IN);
    WDT_EXPIRE_IN <= 1'b0;
    @(negedge MCLK_IN);
    `UNTIL(!RST_PIN_OUT, 200)
    `CHK(k, `WDT_PULSE_PERIODS + 1)
    repeat (6) @(posedge MCLK_IN);
    rd(`PWR_CTRL_ADDR, 8'hff, 8'h00);
    repeat (3) @(posedge MCLK_IN);
    give_verdict();
  end
endmodule

// File: tb/rip_asserts.sv
`timescale 1ns/10ps
module rip_asserts (
  input wire        MCLK_IN,
  input wire        RESETN_IN,
  input wire        RST_PIN_IN,
  input wire        WDT_EXPIRE_IN,
  input wire        IRQ_ZERO_N_IN,
  input wire        IRQ_ONE_N_IN,
  input wire        KBD_IRQ_IN,
  input wire        EN_IRQ_ZERO_IN,
  input wire        IRQ_PEND_IN,
  input wire [3:0]  ADDR_IN,
  input wire [7:0]  WDATA_IN,
  input wire        WR_IN,
  input wire        RST_PIN_OUT,
  input wire        RST_PIN_OE_OUT,
  input wire        CORE_RST_OUT,
  input wire [15:0] FETCH_ADDR_OUT,
  input wire        CPU_CLK_EN_OUT,
  input wire        PER_CLK_EN_OUT,
  input wire        OSC_EN_OUT,
  input wire        ALE_OUT,
  input wire        PSS_OUT
);
  reg [7:0] drv_cnt_reg;
  reg [5:0] pin_cnt_reg;
  // Run lengths; pin count saturates so a long reset never wraps
  always @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      drv_cnt_reg <= 8'h00;
      pin_cnt_reg <= 6'h00;
    end else begin
      drv_cnt_reg <= RST_PIN_OUT ? drv_cnt_reg + 8'h01 : 8'h00;
      if (!RST_PIN_IN)
        pin_cnt_reg <= 6'h00;
      else if (pin_cnt_reg != 6'h3f)
        pin_cnt_reg <= pin_cnt_reg + 6'h01;
    end
  end
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RESETN_IN);
  // Control write taken while the core runs
  sequence s_run_wr;
    WR_IN && ADDR_IN == 4'h0 && CPU_CLK_EN_OUT && !CORE_RST_OUT;
  endsequence
  sequence s_pin_drive;
    RST_PIN_OUT && RST_PIN_OE_OUT;
  endsequence
  chk_wdt_start:
    assert property (WDT_EXPIRE_IN |=> s_pin_drive)
    else $error("reset pin not driven after expiry");
  chk_wdt_width:
    assert property ($fell(RST_PIN_OUT) |-> drv_cnt_reg == 8'h60)
    else $error("watchdog pulse length wrong");
  chk_warm_qual:
    assert property ($rose(CORE_RST_OUT) |->
      $past(pin_cnt_reg, 3) == 6'h18)
    else $error("warm reset qualified at wrong count");
  chk_rst_end:
    assert property (!RST_PIN_IN [*5] |-> !CORE_RST_OUT)
    else $error("core reset outlives reset pin");
  chk_fetch_vec:
    assert property ($fell(CORE_RST_OUT) |-> FETCH_ADDR_OUT == 16'h0000)
    else $error("start address not zero");
  chk_idle_entry:
    assert property (s_run_wr ##0 WDATA_IN[1:0] == 2'h1 |=>
      !CPU_CLK_EN_OUT && PER_CLK_EN_OUT && ALE_OUT && PSS_OUT)
    else $error("idle entry wrong");
  chk_pd_entry:
    assert property (s_run_wr ##0 WDATA_IN[1] |=>
      !OSC_EN_OUT && !ALE_OUT && !PSS_OUT)
    else $error("power-down entry wrong");
  chk_idle_exit:
    assert property (!CPU_CLK_EN_OUT && OSC_EN_OUT && ALE_OUT &&
      IRQ_PEND_IN && !CORE_RST_OUT |=> CPU_CLK_EN_OUT)
    else $error("interrupt did not end idle");
  chk_pd_wake:
    assert property ((!OSC_EN_OUT && EN_IRQ_ZERO_IN && !IRQ_ZERO_N_IN)
      [*3] |-> ##[1:3] OSC_EN_OUT)
    else $error("low pin did not restart oscillator");
  chk_pd_stay:
    assert property ((!OSC_EN_OUT && IRQ_ZERO_N_IN && IRQ_ONE_N_IN &&
      !KBD_IRQ_IN && !RST_PIN_IN) [*4] |=> !OSC_EN_OUT)
    else $error("power-down left without a wake source");
endmodule
bind reset_idle_powerdown_control rip_asserts i_chk (
  .MCLK_IN, .RESETN_IN, .RST_PIN_IN, .WDT_EXPIRE_IN, .IRQ_ZERO_N_IN,
  .IRQ_ONE_N_IN, .KBD_IRQ_IN, .EN_IRQ_ZERO_IN, .IRQ_PEND_IN, .ADDR_IN,
  .WDATA_IN, .WR_IN, .RST_PIN_OUT, .RST_PIN_OE_OUT, .CORE_RST_OUT,
  .FETCH_ADDR_OUT, .CPU_CLK_EN_OUT, .PER_CLK_EN_OUT, .OSC_EN_OUT,
  .ALE_OUT, .PSS_OUT);
